// *** rtl/cdst_pkg.sv ***
// Package of constants, types and ECC functions for the cell diagnostic self-test block
package cdst_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_OPENWIRE = 10'h11B;
  localparam logic [9:0] IDX_COMP = 10'h11C;
  localparam logic [9:0] IDX_TEST = 10'h11D;
  localparam logic [9:0] IDX_DIN0 = 10'h11E;
  localparam logic [9:0] IDX_DIN_CHECK = 10'h126;
  localparam logic [9:0] IDX_CHECK_OUT = 10'h127;
  localparam logic [9:0] IDX_DOUT0 = 10'h128;
  localparam logic [9:0] IDX_STATUS = 10'h130;
  localparam logic [9:0] IDX_CMP_RESULT = 10'h131;
  localparam logic [9:0] BANK_SIZE = 10'h008;

  // Writable field masks and reset value
  localparam logic [7:0] OPENWIRE_MASK = 8'h7F;
  localparam logic [7:0] COMP_MASK = 8'h3F;
  localparam logic [7:0] TEST_MASK = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Test control field positions
  localparam int unsigned TST_ENABLE_BIT = 0;
  localparam int unsigned TST_TYPE_BIT = 1;
  localparam int unsigned TST_SRC_BIT = 2;
  localparam int unsigned TST_DFS_BIT = 3;

  // Status field positions
  localparam int unsigned ST_SEC_BIT = 0;
  localparam int unsigned ST_DED_BIT = 1;
  localparam int unsigned ST_DONE_BIT = 2;

  // Internal test pattern and injected error masks
  localparam logic [63:0] AUTO_PATTERN = 64'hA5C3_0F96_5A3C_F069;
  localparam logic [63:0] INJ_SEC_MASK = 64'h0000_0000_0000_0001;
  localparam logic [63:0] INJ_DED_MASK = 64'h0000_0000_0000_0003;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_RUN = 2'b01,
    TS_HOLD = 2'b10
  } cdst_test_state_e;

  // Inside a register bank of eight bytes
  function automatic logic cdst_in_bank(input logic [9:0] idx, input logic [9:0] base);
    cdst_in_bank = (idx >= base) && (idx < base + BANK_SIZE);
  endfunction : cdst_in_bank

  // Syndrome column of data bit j: j-th 7-bit value with two or more ones
  function automatic logic [6:0] cdst_col(input int unsigned j);
    int unsigned n;
    logic [6:0] v;
    cdst_col = '0;
    n = 0;
    for (int k = 3; k < 128; k++) begin
      v = 7'(k);
      if ($countones(v) > 1) begin
        if (n == j) begin
          cdst_col = v;
        end
        n++;
      end
    end
  endfunction : cdst_col

  // Check byte: seven syndrome bits plus overall parity in bit 7
  function automatic logic [7:0] cdst_check(input logic [63:0] d);
    logic [6:0] s;
    s = '0;
    for (int j = 0; j < 64; j++) begin
      if (d[j]) begin
        s = s ^ cdst_col(j);
      end
    end
    cdst_check = {(^d) ^ (^s), s};
  endfunction : cdst_check

endpackage : cdst_pkg

// *** rtl/cdst_regbus_if.sv ***
// Internal register access carrier between the bus slave and the register file
interface cdst_regbus_if;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;

  modport bus_side (output wr, output rd, output idx, output wdata, input rdata, input hit);
  modport reg_side (input wr, input rd, input idx, input wdata, output rdata, output hit);
endinterface : cdst_regbus_if

// *** rtl/cdst_apb_slave.sv ***
// APB slave front end with zero wait states
module cdst_apb_slave (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Register file side
  cdst_regbus_if.bus_side bus
);
  logic [31:0] prdata_d, prdata_q;
  logic pready_d, pready_q;
  logic err_d, err_q;
  logic setup;

  assign setup = i_psel && !i_penable;
  assign bus.idx = i_paddr[11:2];
  assign bus.wdata = i_pwdata[7:0];
  assign bus.rd = setup && !i_pwrite;
  // Data sits in lane 0, so only that strobe commits a write
  assign bus.wr = i_psel && i_penable && i_pwrite && pready_q && !err_q && i_pstrb[0];

  always_comb begin
    pready_d = setup;
    err_d = setup && (!bus.hit || (i_paddr[1:0] != 2'b00));
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = (bus.hit && !i_pwrite) ? {24'h00_0000, bus.rdata} : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      err_q <= err_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = err_q;
endmodule : cdst_apb_slave

// *** rtl/cdst_ecc_core.sv ***
// SECDED encoder and decoder over a 64-bit word
module cdst_ecc_core
  import cdst_pkg::*;
(
  // Word and check byte under test
  input wire logic [63:0] i_data,
  input wire logic [7:0] i_check,
  // Encoder and decoder results
  output logic [7:0] o_check,
  output logic [63:0] o_corrected,
  output logic o_single,
  output logic o_double
);
  logic [6:0] syn;
  logic par_err;

  always_comb begin
    o_check = cdst_check(i_data);
    syn = o_check[6:0] ^ i_check[6:0];
    par_err = (^i_data) ^ (^i_check);
    o_single = par_err;
    o_double = !par_err && (syn != 7'h00);
    o_corrected = i_data;
    for (int j = 0; j < 64; j++) begin
      if (par_err && (cdst_col(j) == syn)) begin
        o_corrected[j] = !i_data[j];
      end
    end
  end
endmodule : cdst_ecc_core

// *** rtl/cdst_top.sv ***
// Cell diagnostic control: open-wire current, cell comparators and ECC self-test
module cdst_top
  import cdst_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Analog comparator results, asynchronous
  input wire logic [5:0] i_cmp_result_raw,
  // Analog controls
  output logic [5:0] o_bal_openwire_sink_on,
  output logic o_bal0_openwire_source_on,
  output logic [5:0] o_cell_comparator_on,
  // Self-test status
  output logic o_ecc_test_running,
  output logic o_single_error_seen_flag,
  output logic o_double_error_seen_flag
);
  localparam logic [7:0] AUTO_CHECK = cdst_check(AUTO_PATTERN);

  cdst_regbus_if bus ();

  logic [6:0] openwire_d, openwire_q;
  logic [5:0] comp_d, comp_q;
  logic [3:0] test_d, test_q;
  logic [7:0] din_d [0:7];
  logic [7:0] din_q [0:7];
  logic [7:0] din_chk_d, din_chk_q;
  logic [7:0] dout_d [0:7];
  logic [7:0] dout_q [0:7];
  logic [7:0] check_out_d, check_out_q;
  logic sec_d, sec_q, ded_d, ded_q, done_d, done_q;
  logic running_d, running_q;
  cdst_test_state_e state_d, state_q;
  logic [5:0] cmp_s1_q, cmp_s2_q, cmp_res_d, cmp_res_q;
  logic [63:0] din_word, dout_word, src_word, dec_data;
  logic [7:0] dec_check, core_check;
  logic [63:0] core_corr;
  logic core_single, core_double;
  logic [9:0] din_off, dout_off;
  logic status_wr;

  cdst_apb_slave u_apb (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .bus(bus.bus_side)
  );

  assign din_off = bus.idx - IDX_DIN0;
  assign dout_off = bus.idx - IDX_DOUT0;
  assign status_wr = bus.wr && (bus.idx == IDX_STATUS);

  always_comb begin
    for (int b = 0; b < 8; b++) begin
      din_word[b*8 +: 8] = din_q[b];
      dout_word[b*8 +: 8] = dout_q[b];
    end
  end

  assign src_word = test_q[TST_SRC_BIT] ? din_word : AUTO_PATTERN;

  // Manual decoder input ignores function bit
  always_comb begin
    dec_data = din_word;
    dec_check = din_chk_q;
    if (!test_q[TST_SRC_BIT]) begin
      dec_check = AUTO_CHECK;
      dec_data = AUTO_PATTERN ^ (test_q[TST_DFS_BIT] ? INJ_DED_MASK : INJ_SEC_MASK);
    end
  end

  cdst_ecc_core u_ecc (
    .i_data(test_q[TST_TYPE_BIT] ? src_word : dec_data),
    .i_check(dec_check),
    .o_check(core_check),
    .o_corrected(core_corr),
    .o_single(core_single),
    .o_double(core_double)
  );

  // Register read decode
  always_comb begin
    bus.rdata = RST_BYTE;
    bus.hit = 1'b1;
    if (bus.idx == IDX_OPENWIRE) begin
      bus.rdata = {1'b0, openwire_q};
    end else if (bus.idx == IDX_COMP) begin
      bus.rdata = {2'b00, comp_q};
    end else if (bus.idx == IDX_TEST) begin
      bus.rdata = {4'h0, test_q};
    end else if (cdst_in_bank(bus.idx, IDX_DIN0)) begin
      bus.rdata = din_q[din_off[2:0]];
    end else if (bus.idx == IDX_DIN_CHECK) begin
      bus.rdata = din_chk_q;
    end else if (bus.idx == IDX_CHECK_OUT) begin
      bus.rdata = check_out_q;
    end else if (cdst_in_bank(bus.idx, IDX_DOUT0)) begin
      bus.rdata = dout_q[dout_off[2:0]];
    end else if (bus.idx == IDX_STATUS) begin
      bus.rdata = {5'h00, done_q, ded_q, sec_q};
    end else if (bus.idx == IDX_CMP_RESULT) begin
      bus.rdata = {2'b00, cmp_res_q};
    end else begin
      bus.hit = 1'b0;
    end
  end

  // Next state of registers and test sequencer
  always_comb begin
    openwire_d = openwire_q;
    comp_d = comp_q;
    test_d = test_q;
    din_d = din_q;
    din_chk_d = din_chk_q;
    dout_d = dout_q;
    check_out_d = check_out_q;
    state_d = state_q;
    // Result only counts while its comparator is enabled
    cmp_res_d = cmp_s2_q & comp_q;
    if (bus.wr) begin
      if (bus.idx == IDX_OPENWIRE) begin
        openwire_d = bus.wdata[6:0] & OPENWIRE_MASK[6:0];
      end
      if (bus.idx == IDX_COMP) begin
        comp_d = bus.wdata[5:0] & COMP_MASK[5:0];
      end
      if (bus.idx == IDX_TEST) begin
        test_d = bus.wdata[3:0] & TEST_MASK[3:0];
      end
      if (cdst_in_bank(bus.idx, IDX_DIN0)) begin
        din_d[din_off[2:0]] = bus.wdata;
      end
      if (bus.idx == IDX_DIN_CHECK) begin
        din_chk_d = bus.wdata;
      end
    end
    // One pass per raising of the enable, then hold until it drops
    case (state_q)
      TS_IDLE: begin
        if (test_q[TST_ENABLE_BIT]) begin
          state_d = TS_RUN;
        end
      end
      TS_RUN: begin
        state_d = TS_HOLD;
      end
      TS_HOLD: begin
        if (!test_q[TST_ENABLE_BIT]) begin
          state_d = TS_IDLE;
        end
      end
      default: begin
        state_d = TS_IDLE;
      end
    endcase
    if (state_q == TS_RUN) begin
      for (int b = 0; b < 8; b++) begin
        // Encoder test shows the word and its check byte
        dout_d[b] = test_q[TST_TYPE_BIT] ? src_word[b*8 +: 8] : core_corr[b*8 +: 8];
      end
      if (test_q[TST_TYPE_BIT]) begin
        check_out_d = core_check;
      end
    end
    running_d = (state_d != TS_IDLE);
  end

  // Sticky flags: a set in the clearing cycle wins
  always_comb begin
    sec_d = sec_q;
    ded_d = ded_q;
    done_d = done_q;
    if (status_wr) begin
      sec_d = sec_q && !bus.wdata[ST_SEC_BIT];
      ded_d = ded_q && !bus.wdata[ST_DED_BIT];
      done_d = done_q && !bus.wdata[ST_DONE_BIT];
    end
    if (state_q == TS_RUN) begin
      done_d = 1'b1;
      if (!test_q[TST_TYPE_BIT] && core_single) begin
        sec_d = 1'b1;
      end
      if (!test_q[TST_TYPE_BIT] && core_double) begin
        ded_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      openwire_q <= 7'h00;
      comp_q <= 6'h00;
      test_q <= 4'h0;
      for (int b = 0; b < 8; b++) begin
        din_q[b] <= RST_BYTE;
        dout_q[b] <= RST_BYTE;
      end
      din_chk_q <= RST_BYTE;
      check_out_q <= RST_BYTE;
      sec_q <= 1'b0;
      ded_q <= 1'b0;
      done_q <= 1'b0;
      running_q <= 1'b0;
      state_q <= TS_IDLE;
      cmp_s1_q <= 6'h00;
      cmp_s2_q <= 6'h00;
      cmp_res_q <= 6'h00;
    end else begin
      openwire_q <= openwire_d;
      comp_q <= comp_d;
      test_q <= test_d;
      din_q <= din_d;
      dout_q <= dout_d;
      din_chk_q <= din_chk_d;
      check_out_q <= check_out_d;
      sec_q <= sec_d;
      ded_q <= ded_d;
      done_q <= done_d;
      running_q <= running_d;
      state_q <= state_d;
      cmp_s1_q <= i_cmp_result_raw;
      cmp_s2_q <= cmp_s1_q;
      cmp_res_q <= cmp_res_d;
    end
  end

  assign o_bal_openwire_sink_on = openwire_q[6:1];
  assign o_bal0_openwire_source_on = openwire_q[0];
  assign o_cell_comparator_on = comp_q;
  assign o_ecc_test_running = running_q;
  assign o_single_error_seen_flag = sec_q;
  assign o_double_error_seen_flag = ded_q;

  chk_openwire_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    bus.wr && (bus.idx == IDX_OPENWIRE) |=>
      {o_bal_openwire_sink_on, o_bal0_openwire_source_on} == $past(bus.wdata[6:0]))
    else $error("open-wire enables do not follow the write");

  chk_comp_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    bus.wr && (bus.idx == IDX_COMP) |=> o_cell_comparator_on == $past(bus.wdata[5:0]))
    else $error("comparator enables do not follow the write");

  chk_cmp_gated: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    1'b1 |=> cmp_res_q == ($past(i_cmp_result_raw, 3) & $past(comp_q)))
    else $error("comparator result not synchronised raw gated by enable");

  chk_test_pass: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == TS_IDLE && test_q[TST_ENABLE_BIT] |=> state_q == TS_RUN && o_ecc_test_running
      ##1 state_q == TS_HOLD && done_q)
    else $error("self-test did not run one pass");

  chk_enable_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    test_q[TST_ENABLE_BIT] && !(bus.wr && bus.idx == IDX_TEST) |=> test_q[TST_ENABLE_BIT])
    else $error("test enable cleared without a write");

  chk_enc_check: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == TS_RUN && test_q[TST_TYPE_BIT] |=> check_out_q == cdst_check(dout_word))
    else $error("encoder check byte does not match the word");

  chk_sec_result: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == TS_RUN && test_q[2:1] == 2'b00 && !test_q[TST_DFS_BIT] |=>
      sec_q && !$rose(ded_q) && dout_word == AUTO_PATTERN)
    else $error("single-error test did not correct the word");

  chk_ded_result: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == TS_RUN && test_q[2:1] == 2'b00 && test_q[TST_DFS_BIT] |=> ded_q && !$rose(sec_q))
    else $error("double-error test did not flag");

  chk_manual_ignore: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    test_q[TST_SRC_BIT] |-> dec_data == din_word && dec_check == din_chk_q)
    else $error("manual decoder input depends on function select");

  chk_auto_source: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    state_q == TS_RUN && test_q[TST_TYPE_BIT] |=>
      dout_word == ($past(test_q[TST_SRC_BIT]) ? $past(din_word) : AUTO_PATTERN))
    else $error("encoder test used the wrong data source");

  chk_din_word: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    bus.wr && (bus.idx == IDX_DIN0) |=> din_word[7:0] == $past(bus.wdata))
    else $error("data-in byte 0 not stored");

  chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    bus.rd && (bus.idx == IDX_TEST) |-> bus.rdata[7:4] == 4'h0)
    else $error("reserved test control bits read nonzero");
endmodule : cdst_top

// *** test/test_cell_diag_ecc_selftest.sv ***
// Self-checking bench for the cell diagnostic and ECC self-test block
module test_cell_diag_ecc_selftest
  import cdst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic rd;
    logic [7:0] v;
    logic err;
  } cdst_note_s;

  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, src_on, running, sec_f, ded_f;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [3:0] pstrb;
  logic [5:0] raw, sink, cmp_on;
  logic [63:0] w;
  logic [7:0] v;
  int errors, n_checks;
  cdst_note_s notes[$];
  cdst_note_s nt;

  cdst_top cdst_top_i (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cmp_result_raw(raw), .o_bal_openwire_sink_on(sink),
    .o_bal0_openwire_source_on(src_on), .o_cell_comparator_on(cmp_on), .o_ecc_test_running(running),
    .o_single_error_seen_flag(sec_f), .o_double_error_seen_flag(ded_f)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Own SECDED reference, written independently of the design
  function automatic logic [7:0] ecc_ref(input logic [63:0] d);
    logic [6:0] s;
    int n;
    s = '0;
    n = 0;
    for (int k = 3; k < 128; k++) begin
      if ($countones(7'(k)) > 1) begin
        if (n < 64 && d[n]) begin
          s ^= 7'(k);
        end
        n++;
      end
    end
    return {(^d) ^ (^s), s};
  endfunction : ecc_ref

  task automatic summarize();
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic fail(input string m);
    errors++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fail(m);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fail(m);
    end
  endtask : cmp_pin

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One APB transfer; the expected answer is queued for the monitor
  task automatic xfer(input logic wt, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [7:0] e, input logic er);
    int k;
    logic [31:0] x;
    x = rnd();
    notes.push_back('{rd: !wt, v: e, err: er});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wt;
    paddr <= a;
    pwdata <= {x[31:8], d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fail("no ready from slave");
      summarize();
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask : xfer

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    xfer(1'b1, {i, 2'b00}, d, 4'hF, 8'h00, 1'b0);
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    xfer(1'b0, {i, 2'b00}, 8'h00, 4'h0, e, 1'b0);
  endtask : rd

  task automatic wrw(input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      wr(10'(IDX_DIN0 + i), d[8*i+:8]);
    end
  endtask : wrw

  task automatic rdw(input logic [9:0] b, input logic [63:0] d);
    for (int i = 0; i < 8; i++) begin
      rd(10'(b + i), d[8*i+:8]);
    end
  endtask : rdw

  // One self-test pass, then enable and flags cleared by software
  task automatic pass(input logic [7:0] ctl, input logic [7:0] st, input logic [63:0] d, input logic dw,
                      input logic [7:0] ck, input logic dc);
    wr(IDX_TEST, ctl);
    tick(3);
    cmp_pin({5'h00, ded_f, sec_f, running}, {5'h00, st[1:0], 1'b1}, "test pins");
    rd(IDX_STATUS, st); // status flags
    if (dw) begin
      rdw(IDX_DOUT0, d); // output word
    end
    if (dc) begin
      rd(IDX_CHECK_OUT, ck); // encoder check byte
    end
    tick(4);
    rd(IDX_TEST, ctl); // enable never self-clears
    cmp_pin({7'h00, running}, 8'h01, "test stopped early"); // still running
    wr(IDX_TEST, 8'h00); // software clears enable
    wr(IDX_STATUS, 8'h07);
    tick(2);
    cmp_pin({5'h00, ded_f, sec_f, running}, 8'h00, "test not idle"); // disabled
  endtask : pass

  // Monitor: every completed access takes the oldest note
  always @(posedge clk) begin
    if (rst_b === 1'b1 && psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        fail("answer without request");
      end else begin
        nt = notes.pop_front();
        cmp_reg({31'h0, pslverr}, {31'h0, nt.err}, "slave error"); // error response
        if (nt.rd) begin
          cmp_reg(prdata, {24'h00_0000, nt.v}, "read data"); // reserved reads zero
        end
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 32'h0001_679C;
    rst_b = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    raw = 6'h00;
    errors = 0;
    n_checks = 0;
    tick(10);
    rst_b <= 1'b1;
    @(posedge clk);
    cmp_pin({sink, src_on, 1'b0}, 8'h00, "open-wire after reset"); // reset zero
    cmp_pin({cmp_on, running, sec_f}, 8'h00, "controls after reset"); // reset zero
    for (int i = 0; i < 11; i++) begin
      rd(10'(IDX_OPENWIRE + i), 8'h00); // reset values
    end
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'hFFFF_FFFF : rnd();
      raw <= r[21:16];
      wr(IDX_OPENWIRE, r[7:0]);
      wr(IDX_COMP, r[15:8]);
      rd(IDX_OPENWIRE, r[7:0] & OPENWIRE_MASK); // bit 7 reserved
      rd(IDX_COMP, r[15:8] & COMP_MASK); // bits 7 and 6 reserved
      rd(IDX_CMP_RESULT, {2'b00, r[21:16] & r[13:8]}); // gated comparator result
      cmp_pin({1'b0, sink, src_on}, {1'b0, r[6:0]}, "open-wire pins"); // sinks and source
      cmp_pin({2'b00, cmp_on}, {2'b00, r[13:8]}, "comparator pins"); // cell comparators
    end
    v = r[7:0] & OPENWIRE_MASK;
    // Writes without the low strobe must leave the register alone
    xfer(1'b1, {IDX_OPENWIRE, 2'b00}, ~v, 4'hE, 8'h00, 1'b0); // write without the low strobe
    rd(IDX_OPENWIRE, v); // dropped write
    xfer(1'b0, 12'h500, 8'h00, 4'h0, 8'h00, 1'b1); // unmapped read
    xfer(1'b1, {IDX_COMP, 2'b10}, 8'h00, 4'hF, 8'h00, 1'b1); // misaligned write
    rd(IDX_COMP, r[15:8] & COMP_MASK); // misaligned ignored
    wr(IDX_TEST, 8'hF0);
    rd(IDX_TEST, 8'h00); // reserved test bits
    tick(3);
    cmp_pin({7'h00, running}, 8'h00, "test ran while disabled"); // normal operation
    w = {rnd(), rnd()};
    wrw(w);
    rdw(IDX_DIN0, w); // data-in bytes
    pass(8'h07, 8'h04, w, 1'b1, ecc_ref(w), 1'b1); // manual encoder
    pass(8'h0F, 8'h04, w, 1'b1, ecc_ref(w), 1'b1); // encoder ignores function bit
    pass(8'h03, 8'h04, AUTO_PATTERN, 1'b1, ecc_ref(AUTO_PATTERN), 1'b1); // auto encoder
    pass(8'h01, 8'h05, AUTO_PATTERN, 1'b1, 8'h00, 1'b0); // single-error decoder
    pass(8'h09, 8'h06, w, 1'b0, 8'h00, 1'b0); // double-error decoder
    // Manual decoder: one flipped bit against a clean check byte
    wr(IDX_DIN_CHECK, ecc_ref(w));
    wrw(w ^ (64'h1 << r[29:24]));
    pass(8'h0D, 8'h05, w, 1'b1, 8'h00, 1'b0); // manual single error
    wrw(w ^ (64'h3 << r[28:24]));
    pass(8'h05, 8'h06, w, 1'b0, 8'h00, 1'b0); // manual double error
    // Reset in mid-run must clear every control
    wr(IDX_OPENWIRE, 8'h55);
    wr(IDX_TEST, 8'h01);
    rst_b <= 1'b0;
    tick(2);
    cmp_pin({1'b0, sink, src_on}, 8'h00, "open-wire kept over reset"); // reset zero
    cmp_pin({cmp_on, running, sec_f}, 8'h00, "controls kept over reset"); // reset zero
    rst_b <= 1'b1;
    @(posedge clk);
    rd(IDX_OPENWIRE, 8'h00); // reset value
    rd(IDX_TEST, 8'h00); // reset value
    tick(2);
    if (notes.size() != 0) begin
      fail("requests left unanswered");
    end
    summarize();
  end
endmodule : test_cell_diag_ecc_selftest
